// file: rtl/hbd_spi_ctrl.sv
// Serial control, status return and bridge decoding for six half-bridges.
// Assumes SCLK idles low, master holds SI/SCLK low before select falls,
// and SCLK is stopped while select is high.
module hbd_spi_ctrl
   import hbd_pkg::*;
#(
   parameter int NBR    = NUM_BRIDGES,
   parameter int DCNT_W = 8
) (
   input  wire logic           MCLK,             // System clock, 200 MHz
   input  wire logic           SYS_RST,          // Async reset, active high
   input  wire logic           EN,               // Enable pin, low clears command, status snapshot and drives
   input  wire logic           SCLK,             // Serial clock from master
   input  wire logic           CSB_N,            // Chip select, active low
   input  wire logic           SI,               // Serial data in
   output logic                SO,               // Serial data out
   output logic                SO_OE_N,          // Output enable, low drives
   input  wire logic           OC_FAULT,         // Overcurrent shutdown level
   input  wire logic           SUPPLY_FAULT,     // Supply fault level
   input  wire logic           UNDERLOAD_FAULT,  // Under-load fault level
   input  wire logic           THERMAL_WARN,     // Thermal warning level
   input  wire logic           THERMAL_SHUTDOWN, // Latched thermal shutdown
   output logic                FAULT_CLR,        // Clear latched faults pulse
   output logic                ULD_SHUTDOWN_EN,  // Under-load shutdown control
   output logic                OVLO_EN,          // Overvoltage lockout control
   output logic [NBR-1:0]      HIGH_SIDE_SWITCH, // High-side gate drives
   output logic [NBR-1:0]      LOW_SIDE_SWITCH   // Low-side gate drives
);

   if (NBR != NUM_BRIDGES || DCNT_W < 2 ||
       (1 << DCNT_W) <= DEAD_HL_CYC || (1 << DCNT_W) <= DEAD_LH_CYC) begin : g_par_chk
      $error("Six bridges and a dead-time counter wider than the dead time are needed");
   end

   // ---------------------------------------------------------------
   // Link domain: receive on falling SCLK
   // ---------------------------------------------------------------
   logic        rx_arm;
   logic        rx_first_reg;
   logic [15:0] rx_reg,   rx_next;
   logic [3:0]  cnt_reg,  cnt_next;
   logic        ge16_reg, ge16_next;
   logic        frm_tog_reg, frm_tog_next;

   // Select high rearms the frame start without needing an SCLK edge
   assign rx_arm = SYS_RST | CSB_N;

   always_ff @(negedge SCLK or posedge rx_arm) begin
      if (rx_arm) begin
         rx_first_reg <= 1'b1;
      end else begin
         rx_first_reg <= 1'b0;
      end
   end

   // Shift MSB first, count bits modulo 16 plus a reached-16 flag
   always_comb begin
      rx_next   = rx_reg;
      cnt_next  = cnt_reg;
      ge16_next = ge16_reg;
      frm_tog_next = frm_tog_reg;
      if (!CSB_N) begin
         rx_next = {rx_reg[14:0], SI};
         if (rx_first_reg) begin
            cnt_next  = 4'h1;
            ge16_next = 1'b0;
            frm_tog_next = ~frm_tog_reg;  // Tells the system side that bits arrived
         end else begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'hf) begin
               ge16_next = 1'b1;
            end
         end
      end
   end

   // Counter and data hold after select rises, read later by MCLK side
   always_ff @(negedge SCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rx_reg   <= 16'h0000;
         cnt_reg  <= 4'h0;
         ge16_reg <= 1'b0;
         frm_tog_reg <= 1'b0;
      end else begin
         rx_reg   <= rx_next;
         cnt_reg  <= cnt_next;
         ge16_reg <= ge16_next;
         frm_tog_reg <= frm_tog_next;
      end
   end

   // ---------------------------------------------------------------
   // Link domain: transmit on rising SCLK
   // ---------------------------------------------------------------
   logic        tx_first_reg;
   logic [15:0] tx_reg, tx_next;
   logic [15:0] snap_reg, snap_next;
   logic        tsd_s2;

   always_ff @(posedge SCLK or posedge rx_arm) begin
      if (rx_arm) begin
         tx_first_reg <= 1'b1;
      end else begin
         tx_first_reg <= 1'b0;
      end
   end

   // First edge loads the snapshot, later edges pass input through
   always_comb begin
      tx_next = tx_reg;
      if (!CSB_N) begin
         if (tx_first_reg) begin
            tx_next = snap_reg;
         end else begin
            tx_next = {tx_reg[14:0], rx_reg[0]};
         end
      end
   end

   always_ff @(posedge SCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_reg <= 16'h0000;
      end else begin
         tx_reg <= tx_next;
      end
   end

   // Pre-bit slot: thermal flag ORed with upstream input for chaining
   assign SO      = tx_first_reg ? (tsd_s2 | SI) : tx_reg[15];
   assign SO_OE_N = CSB_N;

   // ---------------------------------------------------------------
   // System domain: synchronisers
   // ---------------------------------------------------------------
   logic [6:0] sy1_reg, sy2_reg;
   logic       cs_d_reg;
   logic       cs_s, en_s, oc_s, psf_s, uld_s, tw_s;

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sy1_reg  <= 7'h01;
         sy2_reg  <= 7'h01;
         cs_d_reg <= 1'b1;
      end else begin
         sy1_reg  <= {THERMAL_SHUTDOWN, THERMAL_WARN, UNDERLOAD_FAULT,
                      SUPPLY_FAULT, OC_FAULT, EN, CSB_N};
         sy2_reg  <= sy1_reg;
         cs_d_reg <= sy2_reg[0];
      end
   end

   assign cs_s   = sy2_reg[0];
   assign en_s   = sy2_reg[1];
   assign oc_s   = sy2_reg[2];
   assign psf_s  = sy2_reg[3];
   assign uld_s  = sy2_reg[4];
   assign tw_s   = sy2_reg[5];
   assign tsd_s2 = sy2_reg[6];

   // ---------------------------------------------------------------
   // System domain: commit, status and snapshot
   // ---------------------------------------------------------------
   logic        cs_fall, cs_rise, frame_ok;
   logic [15:0] cmd_reg, cmd_next;
   logic        clr_reg, clr_next;
   logic        seen_tog_reg, seen_tog_next;
   hbd_diag_s   diag_reg, diag_next;

   assign cs_fall = cs_d_reg & ~cs_s;
   assign cs_rise = ~cs_d_reg & cs_s;
   // Static link registers; an unmoved toggle means a select cycle with no bits
   assign frame_ok = ge16_reg & (cnt_reg[2:0] == 3'h0) & ~rx_reg[CMD_SEL] & (frm_tog_reg != seen_tog_reg);

   always_comb begin
      cmd_next  = cmd_reg;
      clr_next  = 1'b0;
      snap_next = snap_reg;
      seen_tog_next = seen_tog_reg;
      diag_next.overcurrent          = oc_s;
      diag_next.supply_fault_flag    = psf_s;
      diag_next.underload_flag       = uld_s;
      diag_next.bridge_enable_report = cmd_reg[CMD_EN_LSB +: 6];
      diag_next.bridge_config_report = cmd_reg[CMD_CFG_LSB +: 6];
      diag_next.thermal_warning_flag = tw_s;
      if (cs_fall) begin
         snap_next = diag_reg;
         seen_tog_next = frm_tog_reg;
      end
      if (cs_rise && frame_ok) begin
         cmd_next = rx_reg;
         clr_next = rx_reg[CMD_CLR];
      end
      if (!en_s) begin
         cmd_next  = CMD_RESET;
         snap_next = DIAG_RESET;
         clr_next  = 1'b0;
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cmd_reg  <= CMD_RESET;
         clr_reg  <= 1'b0;
         snap_reg <= DIAG_RESET;
         diag_reg <= DIAG_RESET;
         seen_tog_reg <= 1'b0;
      end else begin
         cmd_reg  <= cmd_next;
         clr_reg  <= clr_next;
         snap_reg <= snap_next;
         diag_reg <= diag_next;
         seen_tog_reg <= seen_tog_next;
      end
   end

   assign FAULT_CLR       = clr_reg;
   assign ULD_SHUTDOWN_EN = cmd_reg[CMD_ULDSC];
   assign OVLO_EN         = cmd_reg[CMD_OVLO];

   // ---------------------------------------------------------------
   // Bridge drive with dead time
   // ---------------------------------------------------------------
   function automatic logic [DCNT_W-1:0] dead_load(input logic to_high);
      dead_load = to_high ? DCNT_W'(DEAD_LH_CYC - 1) : DCNT_W'(DEAD_HL_CYC - 1);
   endfunction : dead_load

   hbd_br_e             br_reg   [NBR];
   hbd_br_e             br_next  [NBR];
   logic [DCNT_W-1:0]   dc_reg   [NBR];
   logic [DCNT_W-1:0]   dc_next  [NBR];
   logic [NBR-1:0]      hs_next, ls_next, hs_reg, ls_reg;
   logic [NBR-1:0]      want_en, want_hi;

   assign want_en = cmd_reg[CMD_EN_LSB +: NBR] & {NBR{en_s}};
   assign want_hi = cmd_reg[CMD_CFG_LSB +: NBR];

   // Per bridge: float, low, high, or both off while waiting out dead time
   always_comb begin
      for (int i = 0; i < NBR; i++) begin
         br_next[i] = br_reg[i];
         dc_next[i] = dc_reg[i];
         unique case (br_reg[i])
            BR_OFF: begin
               if (want_en[i]) begin
                  br_next[i] = want_hi[i] ? BR_HIGH : BR_LOW;
               end
            end
            BR_LOW: begin
               if (!want_en[i]) begin
                  br_next[i] = BR_OFF;
               end else if (want_hi[i]) begin
                  br_next[i] = BR_DEAD;
                  dc_next[i] = dead_load(1'b1);
               end
            end
            BR_HIGH: begin
               if (!want_en[i]) begin
                  br_next[i] = BR_OFF;
               end else if (!want_hi[i]) begin
                  br_next[i] = BR_DEAD;
                  dc_next[i] = dead_load(1'b0);
               end
            end
            BR_DEAD: begin
               if (!want_en[i]) begin
                  br_next[i] = BR_OFF;
               end else if (dc_reg[i] == '0) begin
                  br_next[i] = want_hi[i] ? BR_HIGH : BR_LOW;
               end else begin
                  dc_next[i] = dc_reg[i] - DCNT_W'(1);
               end
            end
            default: begin
               br_next[i] = BR_OFF;
            end
         endcase
         // Exclusive decode from one state keeps both sides from conducting
         hs_next[i] = (br_next[i] == BR_HIGH);
         ls_next[i] = (br_next[i] == BR_LOW);
      end
   end

   always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < NBR; i++) begin
            br_reg[i] <= BR_OFF;
            dc_reg[i] <= '0;
         end
         hs_reg <= '0;
         ls_reg <= '0;
      end else begin
         br_reg <= br_next;
         dc_reg <= dc_next;
         hs_reg <= hs_next;
         ls_reg <= ls_next;
      end
   end

   assign HIGH_SIDE_SWITCH = hs_reg;
   assign LOW_SIDE_SWITCH  = ls_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_no_shoot;
      @(posedge MCLK) disable iff (SYS_RST) (HIGH_SIDE_SWITCH & LOW_SIDE_SWITCH) == '0;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("Both sides of a bridge on");

   property p_dead_lh;
      @(posedge MCLK) disable iff (SYS_RST) (($past(LOW_SIDE_SWITCH) & HIGH_SIDE_SWITCH) == '0);
   endproperty
   a_dead_lh: assert property (p_dead_lh) else $error("No gap from low to high side");

   property p_dead_hl;
      @(posedge MCLK) disable iff (SYS_RST) (($past(HIGH_SIDE_SWITCH) & LOW_SIDE_SWITCH) == '0);
   endproperty
   a_dead_hl: assert property (p_dead_hl) else $error("No gap from high to low side");

   property p_hiz;
      @(posedge MCLK) disable iff (SYS_RST)
         ((~$past(want_en) & (HIGH_SIDE_SWITCH | LOW_SIDE_SWITCH)) == '0);
   endproperty
   a_hiz: assert property (p_hiz) else $error("Disabled bridge still driven");

   property p_report;
      @(posedge MCLK) disable iff (SYS_RST)
         diag_reg.bridge_enable_report == $past(cmd_reg[CMD_EN_LSB +: 6])
         && diag_reg.bridge_config_report == $past(cmd_reg[CMD_CFG_LSB +: 6]);
   endproperty
   a_report: assert property (p_report) else $error("Status does not mirror command");

   property p_flags;
      @(posedge MCLK) disable iff (SYS_RST)
         diag_reg.overcurrent == $past(oc_s) && diag_reg.thermal_warning_flag == $past(tw_s);
   endproperty
   a_flags: assert property (p_flags) else $error("Fault flag not reported");

   property p_commit;
      @(posedge MCLK) disable iff (SYS_RST) cs_rise && frame_ok && en_s |=> cmd_reg == $past(rx_reg);
   endproperty
   a_commit: assert property (p_commit) else $error("Valid frame not committed");

   property p_reject;
      @(posedge MCLK) disable iff (SYS_RST) cs_rise && !frame_ok && en_s |=> $stable(cmd_reg);
   endproperty
   a_reject: assert property (p_reject) else $error("Invalid frame altered command");

   property p_tx_load;
      @(posedge SCLK) disable iff (SYS_RST) tx_first_reg && !CSB_N |=> tx_reg == $past(snap_reg);
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("Snapshot not loaded for shift out");

   property p_rx_shift;
      @(negedge SCLK) disable iff (SYS_RST) !CSB_N |=> rx_reg[15:1] == $past(rx_reg[14:0]);
   endproperty
   a_rx_shift: assert property (p_rx_shift) else $error("Receive register not shifting");

endmodule : hbd_spi_ctrl

// file: rtl/hbd_pkg.sv
// Constants, frame layout and types of the half-bridge serial control block.
// Assumes one system clock of 200 MHz and a serial clock from the bus master.
// What this block does
// - Status bits 15/14/13/0 flag faults, 1=fault
// - Status bits 12..7 report bridge enables
// - Status bits 6..1 report bridge configuration
// - Thermal shutdown flag precedes frame on output
// - Command bits 12..1 steer six bridges
// - Disabled bridge floats; configuration picks side
// - Never both switches of one bridge
// - Dead time between sides, both directions
// - Valid frame: 16 bits plus multiples of 8
// - Invalid frame discarded, outputs unchanged
// - Under-clocked but countable frame still accepted
// - Thermal flag ORed with input onto output
// - Input sampled on falling clock, MSB first
// - Previous status shifted out on rising clock
// - Select rising commits last 16 bits if valid
// - Output floats while select is high
package hbd_pkg;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int NUM_BRIDGES  = 6;
   localparam int FRAME_BITS   = 16;
   localparam int DG_OCS       = 15;
   localparam int DG_PSF       = 14;
   localparam int DG_ULD       = 13;
   localparam int DG_EN_LSB    = 7;
   localparam int DG_CFG_LSB   = 1;
   localparam int DG_TW        = 0;
   localparam int CMD_CLR      = 15;
   localparam int CMD_SEL      = 14;
   localparam int CMD_ULDSC    = 13;
   localparam int CMD_EN_LSB   = 7;
   localparam int CMD_CFG_LSB  = 1;
   localparam int CMD_OVLO     = 0;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] DIAG_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int MCLK_MHZ            = 200;
   localparam int DEAD_TIME_HL_NS     = 500;
   localparam int DEAD_TIME_LH_NS     = 500;
   localparam int DEAD_HL_CYC_RAW     = (DEAD_TIME_HL_NS * MCLK_MHZ + 999) / 1000;
   localparam int DEAD_LH_CYC_RAW     = (DEAD_TIME_LH_NS * MCLK_MHZ + 999) / 1000;
   localparam int DEAD_HL_CYC         = (DEAD_HL_CYC_RAW < 1) ? 1 : DEAD_HL_CYC_RAW;
   localparam int DEAD_LH_CYC         = (DEAD_LH_CYC_RAW < 1) ? 1 : DEAD_LH_CYC_RAW;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       overcurrent;
      logic       supply_fault_flag;
      logic       underload_flag;
      logic [5:0] bridge_enable_report;
      logic [5:0] bridge_config_report;
      logic       thermal_warning_flag;
   } hbd_diag_s;

   typedef enum logic [3:0] {
      BR_OFF  = 4'b0001,
      BR_LOW  = 4'b0010,
      BR_HIGH = 4'b0100,
      BR_DEAD = 4'b1000
   } hbd_br_e;

endpackage : hbd_pkg

// file: sim/hbd_spi_master.sv
// Behavioural serial bus master standing on the far side of hbd_spi_ctrl.
// Assumes the bench calls xfer one frame at a time; link clock period 160 ns.
module hbd_spi_master (
   output logic      sclk,    // Link clock, still outside frames
   output logic      csb_n,   // Select to device, active low
   output logic      si,      // Data to device
   input  wire logic so,      // Data from device
   input  wire logic so_oe_n  // Low while device drives so
);
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   localparam int HALF = 80;

   // Idle levels of a released bus
   initial begin
      sclk  = 1'b0;
      csb_n = 1'b1;
      si    = 1'b0;
   end

   // One select cycle; pre_si models an upstream flag on the data line
   task automatic xfer(input int nbits, input logic [31:0] data, input logic pre_si,
                       output logic pre, output logic oe, output logic [31:0] rx);
      rx    = '0;
      si    = pre_si;  // Low before select unless upstream flag is modelled
      #HALF;
      csb_n = 1'b0;
      #HALF;           // Select setup met before the first rise
      pre   = so;
      oe    = so_oe_n;
      si    = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         sclk = 1'b1;
         si   = data[i];  // MSB first, steady across the falling edge
         #HALF;
         rx   = {rx[30:0], so};
         sclk = 1'b0;
         #HALF;
      end
      si    = 1'b0;    // Pull-down level once released
      csb_n = 1'b1;
   endtask : xfer
endmodule : hbd_spi_master

// file: sim/test_hex_half_bridge_spi_control.sv
// Self-checking bench for hbd_spi_ctrl with a behavioural serial master.
// Assumes 200 MHz system clock; expectations come from the bench functions.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_hex_half_bridge_spi_control import hbd_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------
   // Signals and design
   // ---------------------------------------------------------------
   logic        mclk, sys_rst, en, tsd, so, so_oe_n, pre, oe;
   logic        fault_clr, uld_en, ovlo;
   logic [3:0]  flt;
   logic [5:0]  hs, ls;
   logic [15:0] cmd_cur;
   logic [31:0] rx;
   wire         sclk, csb_n, si, so_w;
   int          mismatches = 0;
   int          n_checks   = 0;
   int          n_clr      = 0;
   int          clr_exp    = 0;
   int          bad[6]     = '{15, 17, 20, 23, 8, 31};

   // Device drives the line only while enabled
   assign so_w = so_oe_n ? 1'bz : so;

   hbd_spi_ctrl dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .EN(en), .SCLK(sclk), .CSB_N(csb_n),
      .SI(si), .SO(so), .SO_OE_N(so_oe_n), .OC_FAULT(flt[3]), .SUPPLY_FAULT(flt[2]),
      .UNDERLOAD_FAULT(flt[1]), .THERMAL_WARN(flt[0]), .THERMAL_SHUTDOWN(tsd),
      .FAULT_CLR(fault_clr), .ULD_SHUTDOWN_EN(uld_en), .OVLO_EN(ovlo),
      .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls));

   hbd_spi_master master_u (.sclk(sclk), .csb_n(csb_n), .si(si), .so(so_w), .so_oe_n(so_oe_n));

   // ---------------------------------------------------------------
   // Expectations and helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] diag_exp(input logic [15:0] k, input logic [3:0] f);
      return {f[3:1], k[12:1], f[0]};
   endfunction : diag_exp

   function automatic logic [5:0] hs_exp(input logic [15:0] k);
      return k[12:7] & k[6:1];
   endfunction : hs_exp

   function automatic logic [5:0] ls_exp(input logic [15:0] k);
      return k[12:7] & ~k[6:1];
   endfunction : ls_exp

   // Select high time well above the minimum after every frame
   task automatic go(input int n, input logic [31:0] d, input logic p);
      master_u.xfer(n, d, p, pre, oe, rx);
      #100;
   endtask : go

   // Waits past the dead time so a direction change has settled
   task automatic chk_out(input logic [15:0] k);
      #700;
      `CHK("high_side", hs_exp(k), hs)
      `CHK("low_side", ls_exp(k), ls)
      `CHK("uld_shutdown_en", k[13], uld_en)
      `CHK("ovlo_en", k[0], ovlo)
      `CHK("fault_clr", clr_exp, n_clr)
   endtask : chk_out

   // Valid single frame; returned status reflects the previous command
   task automatic cmd(input logic [15:0] k);
      go(16, {16'h0000, k}, 1'b0);
      `CHK("status", diag_exp(cmd_cur, flt), rx[15:0])
      `CHK("status_drive", hs_exp(cmd_cur), rx[12:7] & rx[6:1])
      cmd_cur = k;
      clr_exp += k[15];
      chk_out(k);
   endtask : cmd

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   // ---------------------------------------------------------------
   // Clock, monitor, watchdog
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Both switches of one bridge must never be on together; clear pulses counted
   always @(negedge mclk) begin
      `CHK("overlap", 6'h00, hs & ls)
      if (fault_clr === 1'b1) begin
         n_clr++;
      end
   end

   // Frames take about 3 us each; generous margin over the whole run
   initial begin
      #400us;
      mismatches++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      en      = 1'b0;
      flt     = 4'h0;
      tsd     = 1'b0;
      cmd_cur = CMD_RESET;
      void'($urandom(19));
      repeat (16) @(negedge mclk);
      sys_rst = 1'b0;
      en      = 1'b1;
      repeat (8) @(negedge mclk);
      `CHK("oe_idle", 1'b1, so_oe_n)
      `CHK("bridges_reset", 12'h000, {hs, ls})
      // Dead gap in both directions: low to high, then high to low
      cmd(16'h1f80);
      for (int d = 0; d < 2; d++) begin
         go(16, d ? 32'h1f80 : 32'h1ffe, 1'b0);
         `CHK("dead_gap", 12'h000, {hs, ls})
         cmd_cur = d ? 16'h1f80 : 16'h1ffe;
         chk_out(cmd_cur);
      end
      // Pre-bit: latched flag, upstream flag via data line, no flag
      for (int t = 0; t < 3; t++) begin
         @(negedge mclk);
         tsd = (t == 0);
         repeat (4) @(negedge mclk);
         go(16, {16'h0000, cmd_cur}, t == 1);
         `CHK("pre_bit", (t < 2), pre)
         `CHK("oe_frame", 1'b0, oe)
      end
      // Bad lengths and a set select bit leave everything as it was
      foreach (bad[i]) begin
         go(bad[i], {16'hffff, ~cmd_cur & 16'hbfff}, 1'b0);
         chk_out(cmd_cur);
      end
      go(16, 32'h5ffe, 1'b0);
      chk_out(cmd_cur);
      // Two-device chain: status first, then own input delayed 16 bits
      go(32, 32'hc35a_0e2a, 1'b0);
      `CHK("chain_status", diag_exp(cmd_cur, flt), rx[31:16])
      `CHK("chain_pass", 16'hc35a, rx[15:0])
      cmd_cur = 16'h0e2a;
      chk_out(cmd_cur);
      // Under-clocked chain still countable: last 16 bits commit
      go(24, 32'h00a5_1234, 1'b0);
      `CHK("short_status", diag_exp(cmd_cur, flt), rx[23:8])
      cmd_cur = 16'h1234;
      chk_out(cmd_cur);
      // Random commands and fault levels
      repeat (20) begin
         @(negedge mclk);
         flt = 4'($urandom);
         repeat (4) @(negedge mclk);
         cmd(16'($urandom) & 16'hbfff);
      end
      // Enable pin low clears command and drives
      @(negedge mclk);
      en = 1'b0;
      repeat (8) @(negedge mclk);
      `CHK("en_off", 12'h000, {hs, ls})
      en = 1'b1;
      repeat (8) @(negedge mclk);
      // A select cycle with no clock edges must not restore the cleared command
      go(0, 32'h0000_0000, 1'b0);
      chk_out(CMD_RESET);
      cmd_cur = CMD_RESET;
      cmd(16'h1555);
      end_sim();
   end
endmodule : test_hex_half_bridge_spi_control
